// ==== logic/serial_lane_output_control.sv ====
// file: two-lane source, output mode, polarity and power control
`timescale 1ns/1ps
module serial_lane_output_control
	import lane_ctrl_pkg::*;
#(
	parameter int word_width = 10,
	parameter int depth = fifo_depth
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] link_param_i [link_param_count],
	input wire logic [word_width-1:0] frame_a_i,
	input wire logic [word_width-1:0] frame_b_i,
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	input wire logic [word_width-1:0] enc_a_i,
	input wire logic [word_width-1:0] enc_b_i,
	output logic [word_width-1:0] scr_in_a_o,
	output logic [word_width-1:0] scr_in_b_o,
	output logic [word_width-1:0] lane_a_o,
	output logic [word_width-1:0] lane_b_o,
	output logic lane_valid_o,
	input wire logic lane_ready_i,
	output logic lane_a_falling_edge_o,
	output logic lane_b_falling_edge_o,
	output logic lane_a_power_down_o,
	output logic lane_b_power_down_o
);
	// the prbs-7 recurrence check needs seven bits of history
	initial begin
		if (word_width < 7 || depth < 2)
			$error("serial_lane_output_control: bad parameters");
	end

	reg_req_type req;
	lane_cfg_type cfg_a;
	lane_cfg_type cfg_b;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [1:0] prbs_pattern_select;
	logic [7:0] checksum;
	logic [7:0] next_rdata;
	logic toggle_phase;
	logic [word_width-1:0] prbs_word;
	logic [2*word_width-1:0] fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic [word_width-1:0] next_lane_a;
	logic [word_width-1:0] next_lane_b;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i,
		rd: reg_rd_i};
	assign cfg_a = lane_cfg_type'({ctrl_a[6:4], ctrl_a[2:0]});
	assign cfg_b = lane_cfg_type'({ctrl_b[6:4], ctrl_b[2:0]});

	// separate registers per lane; one write never touches the other
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_a <= ctrl_reset;
			ctrl_b <= ctrl_reset;
			prbs_pattern_select <= prbs_reset;
		end else if (req.wr) begin
			case (req.addr)
			lane_a_output_control_addr:
				ctrl_a <= req.wdata & ctrl_writable_mask;
			lane_b_output_control_addr:
				ctrl_b <= req.wdata & ctrl_writable_mask;
			prbs_ctrl_addr:
				prbs_pattern_select <= req.wdata[1:0];
			default: ;
			endcase
		end
	end

	// checksum recomputed live; both lanes share one link parameter set
	always_comb begin
		checksum = 8'h00;
		for (int i = 0; i < link_param_count; i++)
			checksum = checksum + link_param_i[i];
	end

	always_comb begin
		case (req.addr)
		lane2_config_checksum_addr: next_rdata = checksum;
		lane1_config_checksum_addr: next_rdata = checksum;
		lane_a_output_control_addr: next_rdata = ctrl_a;
		lane_b_output_control_addr: next_rdata = ctrl_b;
		prbs_ctrl_addr: next_rdata = {6'h00, prbs_pattern_select};
		default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 8'h00;
		else if (req.rd)
			reg_rdata_o <= next_rdata;
	end

	// frame data buffered so a stalled lane back-pressures assembly
	word_fifo #(.width(2*word_width), .depth(depth)) u_fifo (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(frame_valid_i),
		.in_ready_o(frame_ready_o),
		.in_data_i({frame_a_i, frame_b_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(lane_ready_i),
		.out_data_o(fifo_out)
	);
	assign fifo_pop = fifo_valid && lane_ready_i;

	prbs_gen #(.width(word_width)) u_prbs (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.prbs_pattern_select_i(prbs_pattern_select),
		.advance_i(lane_ready_i),
		.word_o(prbs_word)
	);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			toggle_phase <= 1'b0;
		else if (lane_ready_i)
			toggle_phase <= ~toggle_phase;
	end

	// scrambler input select
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scr_in_a_o <= '0;
			scr_in_b_o <= '0;
		end else if (lane_ready_i) begin
			scr_in_a_o <= cfg_a.scrambler_input_select ? prbs_word
				: fifo_out[2*word_width-1:word_width];
			scr_in_b_o <= cfg_b.scrambler_input_select ? prbs_word
				: fifo_out[word_width-1:0];
		end
	end

	function automatic logic [word_width-1:0] pick(lane_cfg_type c,
		logic [word_width-1:0] enc, logic [word_width-1:0] prbs,
		logic ph);
		logic [word_width-1:0] v;
		v = '0;
		case (c.mode)
		out_encoder: v = enc;
		out_constant: v = word_width'(const_word);
		out_toggle: v = ph ? word_width'(toggle_one)
			: word_width'(const_word);
		out_prbs: v = prbs;
		default: v = '0;
		endcase
		return c.lane_invert ? ~v : v;
	endfunction

	assign next_lane_a = pick(cfg_a, enc_a_i, prbs_word, toggle_phase);
	assign next_lane_b = pick(cfg_b, enc_b_i, prbs_word, toggle_phase);

	// powered-down lane parks at zero to avoid pad activity
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lane_a_o <= '0;
			lane_b_o <= '0;
			lane_valid_o <= 1'b0;
		end else if (lane_ready_i) begin
			lane_a_o <= cfg_a.lane_power_down ? '0 : next_lane_a;
			lane_b_o <= cfg_b.lane_power_down ? '0 : next_lane_b;
			lane_valid_o <= fifo_pop;
		end
	end

	assign lane_a_falling_edge_o = cfg_a.falling_edge;
	assign lane_b_falling_edge_o = cfg_b.falling_edge;
	assign lane_a_power_down_o = cfg_a.lane_power_down;
	assign lane_b_power_down_o = cfg_b.lane_power_down;

	// previous prbs word; the all-ones seed stands in before the first
	logic [word_width-1:0] prbs_last;
	logic [2*word_width-1:0] prbs_pair;
	logic prbs_started;
	logic prbs7_ok;
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prbs_last <= '1;
			prbs_started <= 1'b0;
		end else if (lane_ready_i) begin
			prbs_last <= prbs_started ? prbs_word : prbs_last;
			prbs_started <= 1'b1;
		end
	end
	assign prbs_pair = {prbs_last, prbs_word};
	// each new bit is the xor of the bits seven and six before it
	always_comb begin
		prbs7_ok = 1'b1;
		for (int m = 0; m < word_width; m++) begin
			if (prbs_pair[m] != (prbs_pair[m+7] ^ prbs_pair[m+6]))
				prbs7_ok = 1'b0;
		end
	end

	a_const_mode: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_a.mode == out_constant
		&& !cfg_a.lane_power_down && !cfg_a.lane_invert
		|=> lane_a_o == '0)
		else $error("constant mode not zero");
	a_invert_flip: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_a.mode == out_constant
		&& !cfg_a.lane_power_down && cfg_a.lane_invert
		|=> lane_a_o == '1)
		else $error("inverted constant not all ones");
	a_encoder_pass: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_b.mode == out_encoder
		&& !cfg_b.lane_power_down
		|=> lane_b_o == ($past(cfg_b.lane_invert) ? ~$past(enc_b_i)
		: $past(enc_b_i)))
		else $error("encoder path wrong");
	a_toggle_alt: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_a.mode == out_toggle
		&& !cfg_a.lane_power_down && !cfg_a.lane_invert
		##1 lane_ready_i && $stable(ctrl_a)
		|=> lane_a_o != $past(lane_a_o) && lane_a_o[word_width-1:1] == '0)
		else $error("toggle not alternating");
	a_prbs_path: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_a.mode == out_prbs
		&& !cfg_a.lane_power_down && !cfg_a.lane_invert
		|=> lane_a_o == $past(prbs_word))
		else $error("prbs mode wrong");
	a_prbs7_taps: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && !prbs_pattern_select[1] |=> prbs7_ok)
		else $error("prbs-7 recurrence broken");
	a_power_down: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_b.lane_power_down |=> lane_b_o == '0)
		else $error("powered lane active");
	a_pd_level: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == lane_a_output_control_addr
		|=> lane_a_power_down_o == $past(reg_wdata_i[pd_bit]))
		else $error("power-down level wrong");
	a_scr_frame: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && !cfg_a.scrambler_input_select
		|=> scr_in_a_o == $past(fifo_out[2*word_width-1:word_width]))
		else $error("scrambler not from frame");
	a_scr_frame_b: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && !cfg_b.scrambler_input_select
		|=> scr_in_b_o == $past(fifo_out[word_width-1:0]))
		else $error("lane b scrambler not from frame");
	a_scr_prbs: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		lane_ready_i && cfg_b.scrambler_input_select
		|=> scr_in_b_o == $past(prbs_word))
		else $error("scrambler not from prbs");
	a_lane_indep: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == lane_a_output_control_addr
		|=> $stable(ctrl_b))
		else $error("lane b changed by lane a write");
	a_lane_b_indep: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == lane_b_output_control_addr
		|=> $stable(ctrl_a))
		else $error("lane a changed by lane b write");
	a_edge_out: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == lane_b_output_control_addr
		|=> lane_b_falling_edge_o == $past(reg_wdata_i[edge_bit]))
		else $error("edge select wrong");
	a_edge_a: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == lane_a_output_control_addr
		|=> lane_a_falling_edge_o == $past(reg_wdata_i[edge_bit]))
		else $error("lane a edge select wrong");
	a_checksum_ro: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == lane1_config_checksum_addr
		|=> reg_rdata_o == $past(checksum))
		else $error("checksum read wrong");
	a_checksum2_ro: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == lane2_config_checksum_addr
		|=> reg_rdata_o == $past(checksum))
		else $error("second checksum read wrong");
	a_read_hold: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_lane_hold: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		!lane_ready_i |=> $stable(lane_a_o) && $stable(lane_b_o)
		&& $stable(lane_valid_o))
		else $error("lane output moved while stalled");
	c_prbs_mode: cover property (@(posedge clock_i)
		cfg_a.mode == out_prbs && lane_valid_o);
	c_toggle_mode: cover property (@(posedge clock_i)
		cfg_b.mode == out_toggle && lane_ready_i);
	c_fifo_full: cover property (@(posedge clock_i) !frame_ready_o);
	c_inverted: cover property (@(posedge clock_i)
		cfg_a.lane_invert && lane_valid_o);
	c_powered_down: cover property (@(posedge clock_i)
		cfg_b.lane_power_down && lane_ready_i);
endmodule

// ==== logic/lane_ctrl_pkg.sv ====
// package: register map, fields and types for the lane output control
package lane_ctrl_pkg;
	localparam logic [11:0] lane2_config_checksum_addr = 12'h84c;
	localparam logic [11:0] lane1_config_checksum_addr = 12'h84d;
	localparam logic [11:0] lane_a_output_control_addr = 12'h870;
	localparam logic [11:0] lane_b_output_control_addr = 12'h871;
	localparam logic [11:0] prbs_ctrl_addr = 12'h80b;
	localparam int scr_in_bit = 6;
	localparam int mode_hi_bit = 5;
	localparam int mode_lo_bit = 4;
	localparam int invert_bit = 2;
	localparam int edge_bit = 1;
	localparam int pd_bit = 0;
	localparam logic [7:0] ctrl_writable_mask = 8'h77;
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [1:0] prbs_reset = 2'h0;
	localparam logic [9:0] const_word = 10'h000;
	localparam logic [9:0] toggle_one = 10'h001;
	localparam int fifo_depth = 32;
	localparam int link_param_count = 12;

	typedef enum logic [1:0] {
		out_encoder,
		out_constant,
		out_toggle,
		out_prbs
	} lane_mode_type;

	typedef struct packed {
		logic scrambler_input_select;
		lane_mode_type mode;
		logic lane_invert;
		logic falling_edge;
		logic lane_power_down;
	} lane_cfg_type;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
endpackage

// ==== logic/word_fifo.sv ====
// file: small flop-based fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
	parameter int width = 10,
	parameter int depth = 32
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [width-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [width-1:0] out_data_o
);
	localparam int aw = $clog2(depth);
	initial begin
		if (depth < 2 || (1 << aw) != depth || width < 1)
			$error("word_fifo: depth must be a power of two >= 2");
	end
	logic [width-1:0] mem [depth];
	logic [aw:0] wr_ptr;
	logic [aw:0] rd_ptr;
	logic push;
	logic pop;
	assign in_ready_o = (wr_ptr - rd_ptr) != (aw+1)'(depth);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr[aw-1:0]];
	always_ff @(posedge clock_i) begin
		if (push)
			mem[wr_ptr[aw-1:0]] <= in_data_i;
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
	a_fifo_no_overflow: assert property (@(posedge clock_i)
		disable iff (sys_rst_i) (wr_ptr - rd_ptr) <= (aw+1)'(depth))
		else $error("fifo count beyond depth");
endmodule

// ==== logic/prbs_gen.sv ====
// file: selectable prbs-7/23/31 generator producing parallel words
`timescale 1ns/1ps
module prbs_gen #(
	parameter int width = 10
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] prbs_pattern_select_i,
	input wire logic advance_i,
	output logic [width-1:0] word_o
);
	logic [30:0] state;
	logic [30:0] next_state;
	logic [width-1:0] next_word;
	always_comb begin
		next_state = state;
		next_word = '0;
		for (int i = 0; i < width; i++) begin
			logic fb;
			fb = 1'b0;
			case (prbs_pattern_select_i)
			2'h2: fb = next_state[22] ^ next_state[17];
			2'h3: fb = next_state[30] ^ next_state[27];
			default: fb = next_state[6] ^ next_state[5];
			endcase
			next_word[width-1-i] = fb;
			next_state = {next_state[29:0], fb};
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= 31'h7fffffff;
			word_o <= '0;
		end else if (advance_i) begin
			state <= next_state;
			word_o <= next_word;
		end
	end
endmodule

// ==== testbench/lane_sink.sv ====
// behavioural lane receiver that counts delivered words
`timescale 1ns/1ps
module lane_sink (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic lane_valid_i,
	input wire logic stall_i,
	output logic lane_ready_o,
	output int words_o
);
	// stall drops ready at once, no grace cycle
	assign lane_ready_o = !stall_i;
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			words_o <= 0;
		end else if (lane_valid_i && lane_ready_o) begin
			words_o <= words_o + 1;
		end
	end
endmodule

// ==== testbench/serial_lane_output_control_test.sv ====
// self-checking bench for the two-lane output control
`timescale 1ns/1ps
module serial_lane_output_control_test;
	import lane_ctrl_pkg::*;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [9:0] lane;
		logic fall;
		logic pd;
	} row_type;
	logic clock_i, sys_rst_i, wr_en, rd_en, fvalid, fready, stall;
	logic lvalid, lready, fall_a, fall_b, pd_a, pd_b;
	logic [11:0] addr;
	logic [7:0] wdata, rdata, sum, got;
	logic [7:0] prm [link_param_count];
	logic [9:0] fa, fb, scr_a, scr_b, lane_a, lane_b, prev, enc_a, enc_b;
	int miscompares, comparisons, cycles, n, k, words;
	row_type rows [6];
	serial_lane_output_control i_serial_lane_output_control (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
		.reg_rdata_o(rdata), .link_param_i(prm), .frame_a_i(fa),
		.frame_b_i(fb), .frame_valid_i(fvalid), .frame_ready_o(fready),
		.enc_a_i(enc_a), .enc_b_i(enc_b), .scr_in_a_o(scr_a),
		.scr_in_b_o(scr_b), .lane_a_o(lane_a), .lane_b_o(lane_b),
		.lane_valid_o(lvalid), .lane_ready_i(lready),
		.lane_a_falling_edge_o(fall_a), .lane_b_falling_edge_o(fall_b),
		.lane_a_power_down_o(pd_a), .lane_b_power_down_o(pd_b));
	lane_sink i_lane_sink (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.lane_valid_i(lvalid), .stall_i(stall), .lane_ready_o(lready),
		.words_o(words));
	task automatic cmp_word(input logic [9:0] g, e, input string m);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] g, e, input string m);
		cmp_word({2'h0, g}, {2'h0, e}, m);
	endtask
	task automatic cmp_bit(input logic g, e, input string m);
		cmp_word({9'h0, g}, {9'h0, e}, m);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clock_i);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clock_i);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge clock_i);
		addr = a;
		rd_en = 1'b1;
		@(negedge clock_i);
		rd_en = 1'b0;
		d = rdata;
	endtask
	task automatic test_done();
		$display("counts: %0d comparisons, %0d miscompares", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// generous ceiling, the run needs well under a thousand cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		{wr_en, rd_en, fvalid, stall, addr, wdata, fa, fb} = '0;
		enc_a = 10'h2c5;
		enc_b = 10'h13a;
		sum = 8'h00;
		for (k = 0; k < link_param_count; k++) begin
			prm[k] = 8'h29 + 8'(k * 8'h13);
			sum = sum + prm[k];
		end
		rows = '{'{8'h00, 10'h2c5, 0, 0}, '{8'h10, 10'h000, 0, 0},
			'{8'h04, 10'h13a, 0, 0}, '{8'h14, 10'h3ff, 0, 0},
			'{8'h02, 10'h2c5, 1, 0}, '{8'h01, 10'h000, 0, 1}};
		sys_rst_i = 1'b1;
		repeat (8) @(negedge clock_i);
		cmp_word(lane_a, 10'h000, "reset lane");
		cmp_bit(pd_a, 1'b0, "reset pd");
		sys_rst_i = 1'b0;
		rd(lane_a_output_control_addr, got);
		cmp_byte(got, ctrl_reset, "reset ctrl a");
		rd(lane_b_output_control_addr, got);
		cmp_byte(got, ctrl_reset, "reset ctrl b");
		rd(prbs_ctrl_addr, got);
		cmp_byte(got, 8'h00, "reset prbs");
		$display("test reset done");
		rd(lane2_config_checksum_addr, got);
		cmp_byte(got, sum, "checksum 2");
		wr(lane1_config_checksum_addr, ~sum);
		rd(lane1_config_checksum_addr, got);
		cmp_byte(got, sum, "checksum 1");
		wr(lane_b_output_control_addr, 8'hff);
		rd(lane_b_output_control_addr, got);
		cmp_byte(got, ctrl_writable_mask, "ctrl mask");
		wr(lane_b_output_control_addr, 8'h04);
		wr(12'h8ff, 8'h55);
		rd(lane_b_output_control_addr, got);
		cmp_byte(got, 8'h04, "unmapped write");
		$display("test registers done");
		for (k = 0; k < 6; k++) begin
			wr(lane_a_output_control_addr, rows[k].ctrl);
			repeat (2) @(negedge clock_i);
			cmp_word(lane_a, rows[k].lane, "lane a");
			cmp_bit(fall_a, rows[k].fall, "edge a");
			cmp_bit(pd_a, rows[k].pd, "pd a");
			cmp_word(lane_b, 10'h2c5, "lane b");
			cmp_bit(fall_b | pd_b, 1'b0, "b flags");
		end
		enc_a = 10'h0f0;
		wr(lane_a_output_control_addr, 8'h00);
		repeat (2) @(negedge clock_i);
		cmp_word(lane_a, 10'h0f0, "encoder follow");
		enc_a = 10'h2c5;
		$display("test rows done");
		wr(lane_a_output_control_addr, 8'h20);
		@(negedge clock_i);
		for (k = 0; k < 4; k++) begin
			prev = lane_a;
			@(negedge clock_i);
			cmp_word(lane_a, {9'h0, ~prev[0]}, "toggle");
		end
		wr(lane_a_output_control_addr, 8'h30);
		for (k = 0; k < 4; k++) begin
			wr(prbs_ctrl_addr, 8'(k));
			rd(prbs_ctrl_addr, got);
			cmp_byte(got, 8'(k), "prbs select");
			prev = lane_a;
			@(negedge clock_i);
			cmp_bit(lane_a !== prev, 1'b1, "prbs lane");
		end
		wr(lane_a_output_control_addr, 8'h40);
		@(negedge clock_i);
		prev = scr_a;
		@(negedge clock_i);
		cmp_bit(scr_a !== prev, 1'b1, "prbs scrambler");
		wr(lane_a_output_control_addr, 8'h00);
		$display("test patterns done");
		// receiver stalls while the buffer is filled to its depth
		stall = 1'b1;
		n = 0;
		for (k = 0; k < 40; k++) begin
			@(negedge clock_i);
			fvalid = fready;
			fa = n[9:0];
			fb = ~n[9:0];
			if (fready === 1'b1) n++;
		end
		@(negedge clock_i);
		fvalid = 1'b0;
		cmp_bit(n == fifo_depth, 1'b1, "fill count");
		cmp_bit(fready, 1'b0, "full");
		stall = 1'b0;
		n = 0;
		for (k = 0; k < 40; k++) begin
			@(negedge clock_i);
			if (lvalid === 1'b1) begin
				cmp_word(scr_a, n[9:0], "frame a");
				cmp_word(scr_b, ~n[9:0], "frame b");
				n++;
			end
		end
		cmp_bit(n == fifo_depth && words == fifo_depth, 1'b1, "drain");
		$display("test buffer done");
		// reset in mid-run must clear settings and the buffer
		wr(lane_b_output_control_addr, 8'h35);
		@(negedge clock_i);
		cmp_bit(pd_b, 1'b1, "pd b set");
		sys_rst_i = 1'b1;
		@(negedge clock_i);
		cmp_word(lane_b, 10'h000, "mid reset lane");
		cmp_bit(pd_b, 1'b0, "mid reset pd");
		sys_rst_i = 1'b0;
		rd(lane_b_output_control_addr, got);
		cmp_byte(got, ctrl_reset, "mid reset ctrl");
		cmp_bit(fready, 1'b1, "mid reset fifo");
		repeat (2) @(negedge clock_i);
		cmp_word(lane_b, enc_b, "mid reset encoder");
		$display("test mid reset done");
		test_done();
	end
endmodule
